/* include/pic_pkg.sv */
// pic_pkg: register map, capability field layout and constant values
// assumes: 32-bit apb register bus, three pwm channels, one clock
package pic_pkg;

  // ***********************************
  // register map
  // ***********************************
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] OFS_PENDING = 12'h008;
  localparam logic [ADDR_W-1:0] OFS_CAP_ONE = 12'h00c;
  localparam logic [ADDR_W-1:0] OFS_CAP_TWO = 12'h010;
  localparam int CHANNELS = 3;
  localparam logic [CHANNELS-1:0] PENDING_RESET = 3'h0;

  // ***********************************
  // capability one fields
  // ***********************************
  localparam int C1_POL_BIT = 28;
  localparam int C1_DUAL_BIT = 27;
  localparam int C1_IRQCFG_LSB = 25;
  localparam int C1_CENTRE_BIT = 23;
  localparam int C1_EDGE_BIT = 22;
  localparam int C1_DBSCL_BIT = 21;
  localparam int C1_DBW_LSB = 16;
  localparam int C1_SCNT_LSB = 13;
  localparam int C1_SCW_LSB = 8;
  localparam int C1_PCW_LSB = 3;
  localparam int C1_CHN_LSB = 0;
  localparam logic default_polarity_flag = 1'h1;
  localparam logic dual_compare_present = 1'h0;
  localparam logic [1:0] irq_configuration_code = 2'h0;
  localparam logic centre_aligned_present = 1'h0;
  localparam logic edge_aligned_present = 1'h1;
  localparam logic deadband_scaler_present = 1'h1;
  localparam logic [4:0] deadband_counter_width = 5'h07;
  localparam logic [2:0] scaler_count = 3'h2;
  localparam logic [4:0] scaler_width = 5'h07;
  localparam logic [4:0] period_counter_width = 5'h07;
  localparam logic [2:0] channel_count = 3'h2;

  // ***********************************
  // capability two fields
  // ***********************************
  localparam int C2_WAVEFORM_SYNC_PRESENT_BIT = 10;
  localparam int C2_WDEPTH_LSB = 6;
  localparam int C2_WWORD_LSB = 1;
  localparam int C2_WMODE_BIT = 0;
  localparam logic waveform_sync_present = 1'h0;
  localparam logic [3:0] waveform_ram_depth = 4'h0;
  localparam logic [4:0] waveform_ram_word_width = 5'h07;
  localparam logic waveform_mode_present = 1'h0;

endpackage

/* src/pic_pending_flag.sv */
// pic_pending_flag: one sticky pending bit, set by an event, cleared by w1c
// assumes: set and clear are synchronous to clk_i
`timescale 1ns/1ns
`default_nettype none
module pic_pending_flag (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic set_i,
  input wire logic clear_i,
  output logic flag_o
);

  logic flag_r;

  // set beats clear so an event in the clearing cycle is kept
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flag_r <= 1'h0;
    end else if (set_i) begin
      flag_r <= 1'h1;
    end else if (clear_i) begin
      flag_r <= 1'h0;
    end
  end

  assign flag_o = flag_r;

endmodule // pic_pending_flag
`default_nettype wire

/* src/pic_regs.sv */
// pic_regs: pending and capability registers of the pwm controller
// assumes: apb slave on clk_i; channel events come from same-clock logic
`timescale 1ns/1ns
`default_nettype none
module pic_regs (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [pic_pkg::ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic pready_o,
  output logic pslverr_o,
  output logic [31:0] prdata_o,
  input wire logic [pic_pkg::CHANNELS-1:0] channel_event_i,
  output logic irq_o
);

  // ***********************************
  // reset release
  // ***********************************
  logic rst_meta_r;
  logic rst_n_r;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_meta_r <= 1'h0;
      rst_n_r <= 1'h0;
    end else begin
      rst_meta_r <= 1'h1;
      rst_n_r <= rst_meta_r;
    end
  end

  // ***********************************
  // capability one
  // ***********************************
  localparam int IRQCFG_W = $bits(pic_pkg::irq_configuration_code);
  localparam int DBW_W = $bits(pic_pkg::deadband_counter_width);
  localparam int SCNT_W = $bits(pic_pkg::scaler_count);
  localparam int SCW_W = $bits(pic_pkg::scaler_width);
  localparam int PCW_W = $bits(pic_pkg::period_counter_width);
  localparam int CHN_W = $bits(pic_pkg::channel_count);
  logic [31:0] cap_one;

  // built from constants only, so it never needs a reset
  always_comb begin
    cap_one = 32'h0;
    cap_one[pic_pkg::C1_POL_BIT] = pic_pkg::default_polarity_flag;
    cap_one[pic_pkg::C1_DUAL_BIT] = pic_pkg::dual_compare_present;
    cap_one[pic_pkg::C1_IRQCFG_LSB +: IRQCFG_W] =
      pic_pkg::irq_configuration_code;
    cap_one[pic_pkg::C1_CENTRE_BIT] = pic_pkg::centre_aligned_present;
    cap_one[pic_pkg::C1_EDGE_BIT] = pic_pkg::edge_aligned_present;
    cap_one[pic_pkg::C1_DBSCL_BIT] = pic_pkg::deadband_scaler_present;
    cap_one[pic_pkg::C1_DBW_LSB +: DBW_W] =
      pic_pkg::deadband_counter_width;
    cap_one[pic_pkg::C1_SCNT_LSB +: SCNT_W] = pic_pkg::scaler_count;
    cap_one[pic_pkg::C1_SCW_LSB +: SCW_W] = pic_pkg::scaler_width;
    cap_one[pic_pkg::C1_PCW_LSB +: PCW_W] =
      pic_pkg::period_counter_width;
    cap_one[pic_pkg::C1_CHN_LSB +: CHN_W] = pic_pkg::channel_count;
  end

  // ***********************************
  // capability two
  // ***********************************
  localparam int WDEPTH_W = $bits(pic_pkg::waveform_ram_depth);
  localparam int WWORD_W = $bits(pic_pkg::waveform_ram_word_width);
  logic [31:0] cap_two;

  // waveform features absent; only the word width reads nonzero
  always_comb begin
    cap_two = 32'h0;
    cap_two[pic_pkg::C2_WAVEFORM_SYNC_PRESENT_BIT] = pic_pkg::waveform_sync_present;
    cap_two[pic_pkg::C2_WDEPTH_LSB +: WDEPTH_W] =
      pic_pkg::waveform_ram_depth;
    cap_two[pic_pkg::C2_WWORD_LSB +: WWORD_W] =
      pic_pkg::waveform_ram_word_width;
    cap_two[pic_pkg::C2_WMODE_BIT] = pic_pkg::waveform_mode_present;
  end

  // ***********************************
  // bus decode
  // ***********************************
  // which register the address names, if any
  typedef enum logic [1:0] {
    PIC_SEL_NONE,
    PIC_SEL_PENDING,
    PIC_SEL_CAP_ONE,
    PIC_SEL_CAP_TWO
  } pic_sel_e;

  pic_sel_e reg_sel;
  logic setup_phase;
  logic access_wr;
  logic mapped;

  // full address compare; aliases of a register answer as unmapped
  always_comb begin
    case (paddr_i)
      pic_pkg::OFS_PENDING: reg_sel = PIC_SEL_PENDING;
      pic_pkg::OFS_CAP_ONE: reg_sel = PIC_SEL_CAP_ONE;
      pic_pkg::OFS_CAP_TWO: reg_sel = PIC_SEL_CAP_TWO;
      default: reg_sel = PIC_SEL_NONE;
    endcase
  end

  assign setup_phase = psel_i && !penable_i;
  assign access_wr = psel_i && penable_i && pwrite_i;
  assign mapped = (reg_sel != PIC_SEL_NONE);

  // zero wait states: every access ends in its first access cycle
  assign pready_o = 1'h1;

  // ***********************************
  // pending flags
  // ***********************************
  logic [pic_pkg::CHANNELS-1:0] pending;
  logic [pic_pkg::CHANNELS-1:0] clear_req;
  logic pending_wr;

  assign pending_wr = access_wr && (reg_sel == PIC_SEL_PENDING);

  // only bits 2..0 act; upper bits of the write are reserved
  assign clear_req = pending_wr ?
                     pwdata_i[pic_pkg::CHANNELS-1:0] :
                     pic_pkg::PENDING_RESET;

  // one flag per channel; bit n follows channel n
  genvar ch;
  generate
    for (ch = 0; ch < pic_pkg::CHANNELS; ch++) begin : g_flag
      pic_pending_flag u_flag (
        .clk_i(clk_i),
        .rst_n_i(rst_n_r),
        .set_i(channel_event_i[ch]),
        .clear_i(clear_req[ch]),
        .flag_o(pending[ch])
      );
    end
  endgenerate

  // ***********************************
  // interrupt request
  // ***********************************
  // level interrupt, no mask of its own
  assign irq_o = |pending;

  // ***********************************
  // read data
  // ***********************************
  logic [31:0] pending_word;
  logic [31:0] prdata_nxt;
  logic [31:0] prdata_r;

  // reserved pending bits read zero
  always_comb begin
    pending_word = 32'h0;
    pending_word[pic_pkg::CHANNELS-1:0] = pending;
  end

  // unmapped addresses read zero
  always_comb begin
    case (reg_sel)
      PIC_SEL_PENDING: prdata_nxt = pending_word;
      PIC_SEL_CAP_ONE: prdata_nxt = cap_one;
      PIC_SEL_CAP_TWO: prdata_nxt = cap_two;
      default: prdata_nxt = 32'h0;
    endcase
  end

  // data is caught in setup so it stands stable through the access cycle
  always_ff @(posedge clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      prdata_r <= 32'h0;
    end else if (setup_phase) begin
      prdata_r <= pwrite_i ? 32'h0 : prdata_nxt;
    end
  end

  // ***********************************
  // slave error
  // ***********************************
  logic pslverr_r;

  // writes to capability registers are dropped silently, no error
  // flag clears once the bus goes idle
  always_ff @(posedge clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      pslverr_r <= 1'h0;
    end else if (setup_phase) begin
      pslverr_r <= !mapped;
    end else if (!psel_i) begin
      pslverr_r <= 1'h0;
    end
  end

  assign prdata_o = prdata_r;
  assign pslverr_o = pslverr_r && psel_i && penable_i;

endmodule // pic_regs
`default_nettype wire

/* tb/pic_regs_chk.sv */
// pic_regs_chk: port assertions for pic_regs
// assumes: one clock, bound to every pic_regs
`timescale 1ns/1ns
`default_nettype none
module pic_regs_chk (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [pic_pkg::ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic [31:0] prdata_o,
  input wire logic [pic_pkg::CHANNELS-1:0] channel_event_i,
  input wire logic irq_o
);
  // ********
  // checks
  // ********
  logic acc;
  logic mapped;
  assign acc = psel_i && penable_i;
  assign mapped = paddr_i inside {pic_pkg::OFS_PENDING,
    pic_pkg::OFS_CAP_ONE, pic_pkg::OFS_CAP_TWO};
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  // setup then access of one read
  sequence s_read(a);
    psel_i && !penable_i && !pwrite_i && paddr_i == a ##1 acc;
  endsequence
  a_cap_one_value: assert property (
    s_read(pic_pkg::OFS_CAP_ONE) |-> prdata_o == 32'h1067473a)
    else $error("capability one wrong");
  a_cap_two_value: assert property (
    s_read(pic_pkg::OFS_CAP_TWO) |-> prdata_o == 32'h0000000e)
    else $error("capability two wrong");
  a_pending_reserved_zero: assert property (
    s_read(pic_pkg::OFS_PENDING) |-> prdata_o[31:3] == 29'h0)
    else $error("reserved pending bits set");
  a_event_raises_irq: assert property (
    |channel_event_i |=> irq_o) else $error("irq missing");
  a_irq_rise_cause: assert property (
    $rose(irq_o) |-> $past(|channel_event_i)) else $error("irq unasked");
  a_irq_fall_cause: assert property (
    $fell(irq_o) |-> $past(acc && pwrite_i &&
    paddr_i == pic_pkg::OFS_PENDING)) else $error("irq dropped");
  a_unmapped_error: assert property (
    acc |-> pslverr_o == !mapped) else $error("error flag wrong");
  a_error_idle_low: assert property (
    !acc |-> !pslverr_o) else $error("error outside access");
  a_ready_high: assert property (pready_o) else $error("ready low");
  a_pending_read_irq: assert property (
    s_read(pic_pkg::OFS_PENDING) |->
    (|prdata_o[pic_pkg::CHANNELS-1:0]) == $past(irq_o))
    else $error("pending read disagrees with irq");
  a_clear_all_drops: assert property (
    acc && pwrite_i && paddr_i == pic_pkg::OFS_PENDING &&
    pwdata_i[pic_pkg::CHANNELS-1:0] == 3'h7 && !(|channel_event_i)
    |=> !irq_o) else $error("irq kept after clearing all");
endmodule // pic_regs_chk
bind pic_regs pic_regs_chk pic_regs_chk_i (
  .clk_i(clk_i),
  .reset_n_i(reset_n_i),
  .psel_i(psel_i),
  .penable_i(penable_i),
  .pwrite_i(pwrite_i),
  .paddr_i(paddr_i),
  .pwdata_i(pwdata_i),
  .pready_o(pready_o),
  .pslverr_o(pslverr_o),
  .prdata_o(prdata_o),
  .channel_event_i(channel_event_i),
  .irq_o(irq_o)
);
`default_nettype wire

/* tb/pic_regs_test.sv */
// pic_regs_test: self-checking bench for pic_regs
// assumes: pic_pkg and the checker compiled before
`timescale 1ns/1ns
`default_nettype none
module pic_regs_test;
  // ********
  // bench
  // ********
  localparam logic [11:0] pend_a = pic_pkg::OFS_PENDING;
  localparam logic [11:0] cap1_a = pic_pkg::OFS_CAP_ONE;
  localparam logic [11:0] cap2_a = pic_pkg::OFS_CAP_TWO;
  logic clk = 1'h0, reset_n = 1'h0, sel = 1'h0, en = 1'h0, wr = 1'h0;
  logic [11:0] adr = 12'h000;
  logic [31:0] wd = 32'h0, rd, prd;
  logic [2:0] ev = 3'h0;
  logic e, rdy, err, irq;
  int err_count = 0, n_compared = 0, cyc = 0;
  always #5 clk = ~clk;
  pic_regs pic_regs_i (.clk_i(clk), .reset_n_i(reset_n), .psel_i(sel),
    .penable_i(en), .pwrite_i(wr), .paddr_i(adr), .pwdata_i(wd),
    .pready_o(rdy), .pslverr_o(err), .prdata_o(prd),
    .channel_event_i(ev), .irq_o(irq));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      $display("unexpected at %0t got %h want %h", $time, got, exp);
      err_count++;
    end
  endtask
  // one apb transfer; read data and error taken at the ready edge
  task automatic bus(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    @(posedge clk);
    #1 sel = 1'h1;
    wr = w;
    adr = a;
    wd = d;
    @(posedge clk);
    #1 en = 1'h1;
    do @(posedge clk); while (rdy !== 1'h1);
    rd = prd;
    e = err;
    #1 sel = 1'h0;
    en = 1'h0;
  endtask
  task automatic pulse(input logic [2:0] m);
    @(posedge clk);
    #1 ev = m;
    @(posedge clk);
    #1 ev = 3'h0;
  endtask
  // second pass runs after writes, which must not stick
  task automatic t_caps;
    for (int i = 0; i < 2; i++) begin
      bus(1'h0, cap1_a, 32'h0);
      chk(rd, 32'h1067473a);
      bus(1'h0, cap2_a, 32'h0);
      chk(rd, 32'h0000000e);
      bus(1'h1, cap1_a, 32'hffffffff);
      chk(e, 1'h0);
      bus(1'h1, cap2_a, 32'hffffffff);
      chk(e, 1'h0);
    end
  endtask
  task automatic t_unmapped;
    bus(1'h0, 12'h014, 32'h0);
    chk(rd, 32'h0);
    chk(e, 1'h1);
  endtask
  task automatic t_pending;
    bus(1'h0, pend_a, 32'h0);
    chk(rd, 32'h0);
    for (int n = 0; n < 3; n++) begin
      pulse(3'h1 << n);
      chk(irq, 1'h1);
      bus(1'h0, pend_a, 32'h0);
      chk(rd, 32'h1 << n);
      bus(1'h1, pend_a, 32'hfffffff8);
      chk(irq, 1'h1);
      bus(1'h1, pend_a, 32'h1 << n);
      chk(irq, 1'h0);
    end
    pulse(3'h5);
    bus(1'h1, pend_a, 32'h1);
    chk(irq, 1'h1);
    bus(1'h0, pend_a, 32'h0);
    chk(rd, 32'h4);
    reset_n = 1'h0;
    #20 chk(irq, 1'h0);
    reset_n = 1'h1;
    repeat (3) @(posedge clk);
    bus(1'h0, pend_a, 32'h0);
    chk(rd, 32'h0);
  endtask
  // event and clear in one cycle: the event must win
  task automatic t_collide;
    fork
      bus(1'h1, pend_a, 32'h2);
      begin
        repeat (2) @(posedge clk);
        #1 ev = 3'h2;
        @(posedge clk);
        #1 ev = 3'h0;
      end
    join
    chk(irq, 1'h1);
    bus(1'h0, pend_a, 32'h0);
    chk(rd, 32'h2);
    bus(1'h1, pend_a, 32'h7);
    chk(irq, 1'h0);
  endtask
  task automatic conclude;
    if (err_count == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // run is some 110 cycles; ceiling leaves wide margin
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      conclude();
    end
  end
  initial begin
    repeat (16) @(posedge clk);
    #1 reset_n = 1'h1;
    repeat (3) @(posedge clk);
    t_caps();
    t_unmapped();
    t_pending();
    t_collide();
    conclude();
  end
endmodule // pic_regs_test
`default_nettype wire
